// ---- core/lblu_unit.sv ----
// Ladder bit logic unit: executes bit input and output instructions
`timescale 1ns/1ps
`include "lblu_defines.svh"
module lblu_unit (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      scan_start,
  input  wire logic                      instr_valid,
  input  wire logic [`LBLU_OP_W-1:0]     instr_op,
  input  wire logic [1:0]                instr_form,
  input  wire logic [`LBLU_EDGE_W-1:0]   instr_edge,
  input  wire logic [`LBLU_ADDR_W-1:0]   op_addr,
  input  wire logic [`LBLU_WORD_W-1:0]   op_word,
  input  wire logic [`LBLU_SEL_W-1:0]    op_bit,
  input  wire logic [`LBLU_CNT_W-1:0]    op_count,
  output logic                           cond,
  output logic                           done,
  output logic                           stack_err,
  output logic                           wr_en,
  output logic [`LBLU_ADDR_W-1:0]        wr_addr,
  output logic [`LBLU_WORD_W-1:0]        wr_mask,
  output logic [`LBLU_WORD_W-1:0]        wr_data
);

  lblu_pkg::lblu_state_s s;       // Registered state
  lblu_pkg::lblu_state_s next_s;  // Next state
  lblu_pkg::lblu_op_e    op;      // Decoded instruction
  logic                  cur_bit; // Addressed operand bit
  logic                  fresh;   // Condition history of this edge instance

  // Single bit mask, used by every single-bit write
  function automatic logic [`LBLU_WORD_W-1:0] bit_mask(
    input logic [`LBLU_SEL_W-1:0] sel
  );
    bit_mask = '0;
    bit_mask[sel] = 1'b1;
  endfunction

  // Run of count bits from start; bits past the word end are dropped
  function automatic logic [`LBLU_WORD_W-1:0] run_mask(
    input logic [`LBLU_SEL_W-1:0] start,
    input logic [`LBLU_CNT_W-1:0] count
  );
    logic [`LBLU_WORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < `LBLU_WORD_W; i++) begin
      if ((i >= int'(start)) && (i < int'(start) + int'(count))) begin
        m[i] = 1'b1;
      end
    end
    run_mask = m;
  endfunction

  assign op      = lblu_pkg::lblu_op_e'(instr_op);
  assign cur_bit = op_word[op_bit];
  assign fresh   = s.prev[instr_edge];

  // Next state: one instruction per valid cycle
  always_comb begin
    logic v;  // Operand value after optional inversion
    logic b;  // Block result taken from the stack
    v = 1'b0;
    b = 1'b0;
    next_s = s;
    next_s.done    = 1'b0;
    next_s.wr_en   = 1'b0;
    next_s.wr_mask = '0;
    next_s.wr_data = '0;
    // Stale blocks from an aborted scan must not leak into the next one
    if (scan_start) begin
      next_s.sp = `LBLU_RST_SP;
    end
    if (instr_valid) begin
      next_s.done    = 1'b1;
      next_s.wr_addr = op_addr;
      unique case (op)
        // Loads open a new block and save the old one
        lblu_pkg::LBLU_OP_LOAD, lblu_pkg::LBLU_OP_LOADN: begin
          if (next_s.sp == `LBLU_SP_W'(`LBLU_STK_DEPTH)) begin
            next_s.err = 1'b1;
          end else begin
            next_s.stk[next_s.sp[2:0]] = s.cond;
            next_s.sp = next_s.sp + 1'b1;
          end
          next_s.cond = (op == lblu_pkg::LBLU_OP_LOAD) ? cur_bit : ~cur_bit;
        end
        // Serial and parallel contacts
        lblu_pkg::LBLU_OP_AND:  next_s.cond = s.cond & cur_bit;
        lblu_pkg::LBLU_OP_ANDN: next_s.cond = s.cond & ~cur_bit;
        lblu_pkg::LBLU_OP_OR:   next_s.cond = s.cond | cur_bit;
        lblu_pkg::LBLU_OP_ORN:  next_s.cond = s.cond | ~cur_bit;
        // Block merges pop the saved block
        lblu_pkg::LBLU_OP_BLKAND, lblu_pkg::LBLU_OP_BLKOR: begin
          if (next_s.sp == `LBLU_RST_SP) begin
            next_s.err = 1'b1;  // Underflow leaves condition alone
          end else begin
            next_s.sp = next_s.sp - 1'b1;
            b = s.stk[next_s.sp[2:0]];
            next_s.cond = (op == lblu_pkg::LBLU_OP_BLKAND) ?
                          (s.cond & b) : (s.cond | b);
          end
        end
        // Condition modifiers
        lblu_pkg::LBLU_OP_NOT: next_s.cond = ~s.cond;
        lblu_pkg::LBLU_OP_UP: begin
          next_s.cond = s.cond & ~fresh;
          next_s.prev[instr_edge] = s.cond;
        end
        lblu_pkg::LBLU_OP_DOWN: begin
          next_s.cond = ~s.cond & fresh;
          next_s.prev[instr_edge] = s.cond;
        end
        // Word bit tests in three forms
        lblu_pkg::LBLU_OP_WBT, lblu_pkg::LBLU_OP_WBTN: begin
          v = (op == lblu_pkg::LBLU_OP_WBT) ? cur_bit : ~cur_bit;
          unique case (instr_form)
            `LBLU_FORM_AND: next_s.cond = s.cond & v;
            `LBLU_FORM_OR:  next_s.cond = s.cond | v;
            default: begin
              // Load form, also taken for an unused form code
              if (next_s.sp == `LBLU_SP_W'(`LBLU_STK_DEPTH)) begin
                next_s.err = 1'b1;
              end else begin
                next_s.stk[next_s.sp[2:0]] = s.cond;
                next_s.sp = next_s.sp + 1'b1;
              end
              next_s.cond = v;
            end
          endcase
        end
        // Plain outputs write every time
        lblu_pkg::LBLU_OP_OUT, lblu_pkg::LBLU_OP_WBOUT, lblu_pkg::LBLU_OP_OUTN: begin
          next_s.wr_en   = 1'b1;
          next_s.wr_mask = bit_mask(op_bit);
          v = (op == lblu_pkg::LBLU_OP_OUTN) ? ~s.cond : s.cond;
          next_s.wr_data = v ? bit_mask(op_bit) : '0;
        end
        // Latch: saved block is the set line, condition the reset line
        lblu_pkg::LBLU_OP_KEEP: begin
          if (next_s.sp == `LBLU_RST_SP) begin
            next_s.err = 1'b1;
          end else begin
            next_s.sp = next_s.sp - 1'b1;
            b = s.stk[next_s.sp[2:0]];
            next_s.wr_en   = 1'b1;
            next_s.wr_mask = bit_mask(op_bit);
            v = ~s.cond & (b | cur_bit);
            next_s.wr_data = v ? bit_mask(op_bit) : '0;
          end
        end
        // Pulse outputs share the edge history
        lblu_pkg::LBLU_OP_PUP, lblu_pkg::LBLU_OP_PDN: begin
          next_s.wr_en   = 1'b1;
          next_s.wr_mask = bit_mask(op_bit);
          v = (op == lblu_pkg::LBLU_OP_PUP) ?
              (s.cond & ~fresh) : (~s.cond & fresh);
          next_s.wr_data = v ? bit_mask(op_bit) : '0;
          next_s.prev[instr_edge] = s.cond;
        end
        // Set and clear act only while the condition is ON
        lblu_pkg::LBLU_OP_SET, lblu_pkg::LBLU_OP_WBON: begin
          next_s.wr_en   = s.cond;
          next_s.wr_mask = bit_mask(op_bit);
          next_s.wr_data = bit_mask(op_bit);
        end
        lblu_pkg::LBLU_OP_CLR, lblu_pkg::LBLU_OP_WBOFF: begin
          next_s.wr_en   = s.cond;
          next_s.wr_mask = bit_mask(op_bit);
        end
        // Range writes stay inside one word
        lblu_pkg::LBLU_OP_RON: begin
          next_s.wr_en   = s.cond;
          next_s.wr_mask = run_mask(op_bit, op_count);
          next_s.wr_data = run_mask(op_bit, op_count);
        end
        lblu_pkg::LBLU_OP_ROFF: begin
          next_s.wr_en   = s.cond;
          next_s.wr_mask = run_mask(op_bit, op_count);
        end
        // Unknown code acts as no operation
        default: begin
          next_s.done = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s      <= '0;
      s.cond <= `LBLU_RST_COND;
      s.sp   <= `LBLU_RST_SP;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flops
  assign cond      = s.cond;
  assign done      = s.done;
  assign stack_err = s.err;
  assign wr_en     = s.wr_en;
  assign wr_addr   = s.wr_addr;
  assign wr_mask   = s.wr_mask;
  assign wr_data   = s.wr_data;

  // Checks on the instruction results
  logic go;  // Accepted instruction this cycle
  assign go = instr_valid && !reset;

  property p_load;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_LOAD |=> cond == $past(cur_bit);
  endproperty
  a_load: assert property (p_load) else $error("load condition wrong");

  property p_loadn;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_LOADN |=> cond != $past(cur_bit);
  endproperty
  a_loadn: assert property (p_loadn) else $error("inverted load wrong");

  property p_and;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_AND && !cur_bit |=> !cond;
  endproperty
  a_and: assert property (p_and) else $error("and did not clear");

  property p_orn;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_ORN && !cur_bit |=> cond;
  endproperty
  a_orn: assert property (p_orn) else $error("inverted or did not set");

  property p_push;
    @(posedge clk) disable iff (reset)
      go && !scan_start && op == lblu_pkg::LBLU_OP_LOAD && s.sp < 4'h8
      |=> s.sp == $past(s.sp) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("load did not push");

  property p_blk;
    @(posedge clk) disable iff (reset)
      go && !scan_start && op == lblu_pkg::LBLU_OP_BLKAND && s.sp != 4'h0 && !s.cond
      |=> !cond && s.sp == $past(s.sp) - 4'h1;
  endproperty
  a_blk: assert property (p_blk) else $error("block and wrong");

  property p_not;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_NOT |=> cond != $past(s.cond);
  endproperty
  a_not: assert property (p_not) else $error("invert failed");

  property p_up;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_UP && s.cond && !fresh
      |=> cond ##0 s.prev[$past(instr_edge)];
  endproperty
  a_up: assert property (p_up) else $error("rising condition missed");

  property p_out;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_OUT
      |=> wr_en && done && ((wr_data & wr_mask) != 16'h0) == $past(s.cond);
  endproperty
  a_out: assert property (p_out) else $error("output write wrong");

  property p_set_idle;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_SET && !s.cond |=> !wr_en;
  endproperty
  a_set_idle: assert property (p_set_idle) else $error("set wrote while off");

  property p_clr;
    @(posedge clk) disable iff (reset)
      go && op == lblu_pkg::LBLU_OP_WBOFF && s.cond |=> wr_en && wr_data == 16'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not write zero");

  // Main scenarios
  c_blk_or: cover property (@(posedge clk) go && op == lblu_pkg::LBLU_OP_BLKOR);
  c_pup:    cover property (@(posedge clk) go && op == lblu_pkg::LBLU_OP_PUP && s.cond);
  c_ron:    cover property (@(posedge clk) go && op == lblu_pkg::LBLU_OP_RON && s.cond);
  c_keep:   cover property (@(posedge clk) go && op == lblu_pkg::LBLU_OP_KEEP);

endmodule // lblu_unit

// ---- core/lblu_defines.svh ----
// Constants for the ladder bit logic unit
// Contract
// - Load starts block, condition equals operand bit
// - Inverted load starts block with complemented bit
// - AND merges operand bit into condition
// - Inverted AND merges complemented operand bit
// - OR merges operand bit into condition
// - Inverted OR merges complemented operand bit
// - Block AND combines two latest blocks
// - Block OR combines two latest blocks
// - Condition invert complements the condition
// - Rising condition is ON one scan
// - Falling condition is ON one scan
// - Word bit test in load/AND/OR forms
// - Inverted word bit test yields complement
// - Output writes condition into addressed bit
// - Inverted output writes complemented condition
// - Latch sets on set, clears on reset
// - Rising pulse output ON one scan
// - Falling pulse output ON one scan
// - Set forces bit ON while condition ON
// - Clear forces bit OFF while condition ON
// - Range set turns ON consecutive bits
// - Range clear turns OFF consecutive bits
`ifndef LBLU_DEFINES_SVH
`define LBLU_DEFINES_SVH

// Widths and depths
`define LBLU_OP_W        10
`define LBLU_ADDR_W      16
`define LBLU_WORD_W      16
`define LBLU_SEL_W       4
`define LBLU_CNT_W       5
`define LBLU_EDGE_W      5
`define LBLU_EDGES       32
`define LBLU_STK_DEPTH   8
`define LBLU_SP_W        4

// Function codes carried by the instructions
`define LBLU_FC_NOT      10'h208
`define LBLU_FC_UP       10'h209
`define LBLU_FC_DOWN     10'h20A
`define LBLU_FC_WBT      10'h15E
`define LBLU_FC_WBTN     10'h15F
`define LBLU_FC_WBOUT    10'h216
`define LBLU_FC_KEEP     10'h00B
`define LBLU_FC_PUP      10'h00D
`define LBLU_FC_PDN      10'h00E
`define LBLU_FC_WBON     10'h214
`define LBLU_FC_WBOFF    10'h215
`define LBLU_FC_RON      10'h212
`define LBLU_FC_ROFF     10'h213

// Codes for instructions that carry no function code
`define LBLU_FC_LOAD     10'h380
`define LBLU_FC_LOADN    10'h381
`define LBLU_FC_AND      10'h382
`define LBLU_FC_ANDN     10'h383
`define LBLU_FC_OR       10'h384
`define LBLU_FC_ORN      10'h385
`define LBLU_FC_BLKAND   10'h386
`define LBLU_FC_BLKOR    10'h387
`define LBLU_FC_OUT      10'h388
`define LBLU_FC_OUTN     10'h389
`define LBLU_FC_SET      10'h38A
`define LBLU_FC_CLR      10'h38B

// Bit test forms
`define LBLU_FORM_LOAD   2'h0
`define LBLU_FORM_AND    2'h1
`define LBLU_FORM_OR     2'h2

// Reset values
`define LBLU_RST_COND    1'h0
`define LBLU_RST_SP      4'h0

`endif

// ---- core/lblu_pkg.sv ----
// Types for the ladder bit logic unit
`include "lblu_defines.svh"
package lblu_pkg;

  // Instruction codes
  typedef enum logic [`LBLU_OP_W-1:0] {
    LBLU_OP_LOAD   = `LBLU_FC_LOAD,
    LBLU_OP_LOADN  = `LBLU_FC_LOADN,
    LBLU_OP_AND    = `LBLU_FC_AND,
    LBLU_OP_ANDN   = `LBLU_FC_ANDN,
    LBLU_OP_OR     = `LBLU_FC_OR,
    LBLU_OP_ORN    = `LBLU_FC_ORN,
    LBLU_OP_BLKAND = `LBLU_FC_BLKAND,
    LBLU_OP_BLKOR  = `LBLU_FC_BLKOR,
    LBLU_OP_NOT    = `LBLU_FC_NOT,
    LBLU_OP_UP     = `LBLU_FC_UP,
    LBLU_OP_DOWN   = `LBLU_FC_DOWN,
    LBLU_OP_WBT    = `LBLU_FC_WBT,
    LBLU_OP_WBTN   = `LBLU_FC_WBTN,
    LBLU_OP_OUT    = `LBLU_FC_OUT,
    LBLU_OP_OUTN   = `LBLU_FC_OUTN,
    LBLU_OP_WBOUT  = `LBLU_FC_WBOUT,
    LBLU_OP_KEEP   = `LBLU_FC_KEEP,
    LBLU_OP_PUP    = `LBLU_FC_PUP,
    LBLU_OP_PDN    = `LBLU_FC_PDN,
    LBLU_OP_SET    = `LBLU_FC_SET,
    LBLU_OP_CLR    = `LBLU_FC_CLR,
    LBLU_OP_WBON   = `LBLU_FC_WBON,
    LBLU_OP_WBOFF  = `LBLU_FC_WBOFF,
    LBLU_OP_RON    = `LBLU_FC_RON,
    LBLU_OP_ROFF   = `LBLU_FC_ROFF
  } lblu_op_e;

  // Whole state of the unit
  typedef struct packed {
    logic                        cond;     // Current execution condition
    logic [`LBLU_STK_DEPTH-1:0]  stk;      // Pending block results
    logic [`LBLU_SP_W-1:0]       sp;       // Stack fill level
    logic [`LBLU_EDGES-1:0]      prev;     // Edge history per instance
    logic                        done;     // Instruction finished
    logic                        err;      // Sticky stack fault
    logic                        wr_en;    // Memory write strobe
    logic [`LBLU_ADDR_W-1:0]     wr_addr;  // Word address of write
    logic [`LBLU_WORD_W-1:0]     wr_mask;  // Bits to change
    logic [`LBLU_WORD_W-1:0]     wr_data;  // New bit values
  } lblu_state_s;

endpackage

// ---- verification/lblu_mem_model.sv ----
// Data memory model on the far side of the ladder bit logic unit
`timescale 1ns/1ps
`include "lblu_defines.svh"
module lblu_mem_model (
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [`LBLU_ADDR_W-1:0] wr_addr,
  input  wire logic [`LBLU_WORD_W-1:0] wr_mask,
  input  wire logic [`LBLU_WORD_W-1:0] wr_data,
  input  wire logic [`LBLU_ADDR_W-1:0] rd_addr,
  output logic      [`LBLU_WORD_W-1:0] rd_word
);
  // Sixteen words; upper address bits alias, enough for this bench
  logic [`LBLU_WORD_W-1:0] mem [16];
  // Only masked bits change, the rest of the word is kept
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr[3:0]] <= (mem[wr_addr[3:0]] & ~wr_mask) | (wr_data & wr_mask);
    end
  end
  // Sequencer side: operand word is fetched before each instruction
  assign rd_word = mem[rd_addr[3:0]];
endmodule // lblu_mem_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the ladder bit logic unit
`timescale 1ns/1ps
`include "lblu_defines.svh"
module tb_top;
  logic                    clk;         // 25 MHz clock
  logic                    reset;       // Synchronous reset
  logic                    scan_start;  // Scan boundary strobe
  logic                    instr_valid; // Instruction strobe
  logic [`LBLU_OP_W-1:0]   instr_op;    // Instruction code
  logic [1:0]              instr_form;  // Bit test form
  logic [`LBLU_EDGE_W-1:0] instr_edge;  // Edge instance
  logic [`LBLU_ADDR_W-1:0] op_addr;     // Operand word address
  logic [`LBLU_WORD_W-1:0] op_word;     // Operand word from memory
  logic [`LBLU_SEL_W-1:0]  op_bit;      // Bit or start position
  logic [`LBLU_CNT_W-1:0]  op_count;    // Range length
  logic                    cond;        // Execution condition
  logic                    done;        // Completion pulse
  logic                    stack_err;   // Sticky stack fault
  logic                    wr_en;       // Memory write strobe
  logic [`LBLU_ADDR_W-1:0] wr_addr;     // Write address
  logic [`LBLU_WORD_W-1:0] wr_mask;     // Write mask
  logic [`LBLU_WORD_W-1:0] wr_data;     // Write data
  int                      errors;      // Mismatch count
  int                      cmp_count;   // Comparison count
  logic [`LBLU_WORD_W-1:0] seen_mask;   // Write mask caught while it stands

  lblu_unit dut (.clk(clk), .reset(reset), .scan_start(scan_start), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_form(instr_form), .instr_edge(instr_edge), .op_addr(op_addr),
    .op_word(op_word), .op_bit(op_bit), .op_count(op_count), .cond(cond), .done(done),
    .stack_err(stack_err), .wr_en(wr_en), .wr_addr(wr_addr), .wr_mask(wr_mask),
    .wr_data(wr_data));
  lblu_mem_model mem (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_mask(wr_mask),
    .wr_data(wr_data), .rd_addr(op_addr), .rd_word(op_word));

  // Free-running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize;
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One instruction; returns after the memory has taken any write
  task automatic run(input logic [9:0] op, input logic [15:0] a, input logic [3:0] b,
                     input logic [4:0] e, input logic [1:0] f, input logic [4:0] n);
    @(negedge clk);
    instr_valid = 1'b1;
    instr_op    = op;
    op_addr     = a;
    op_bit      = b;
    instr_edge  = e;
    instr_form  = f;
    op_count    = n;
    @(negedge clk);
    instr_valid = 1'b0;
    seen_mask   = wr_mask;
    check(16'(done), 16'h0001);
    @(posedge clk);
    #1;
  endtask

  // Instruction then condition compare
  task automatic in_step(input logic [9:0] op, input logic [3:0] b, input logic [4:0] e,
                         input logic [1:0] f, input logic ex);
    run(op, 16'h0001 + 16'(op == `LBLU_FC_WBTN || op == `LBLU_FC_WBT), b, e, f, 5'h00);
    check(16'(cond), 16'(ex));
  endtask

  // Instruction then compare of the written word
  task automatic out_step(input logic [9:0] op, input logic [15:0] a, input logic [3:0] b,
                          input logic [4:0] n, input logic [4:0] e, input logic [15:0] ex);
    run(op, a, b, e, 2'h0, n);
    check(mem.mem[a[3:0]], ex);
  endtask

  // Scan boundary, empties the block stack
  task automatic scan;
    @(negedge clk);
    scan_start = 1'b1;
    @(negedge clk);
    scan_start = 1'b0;
  endtask

  // Reset held for 2 cycles, then idle outputs compared
  task automatic do_reset;
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check({cond, done, stack_err, wr_en, wr_mask[11:0]}, 16'h0000);
  endtask

  // Contacts, block merges and bit tests; word 1 = 00A5, word 2 = 0010
  task automatic t_inputs;
    scan();
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_ANDN, 4'h1, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_AND, 4'h1, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_OR, 4'h2, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_LOADN, 4'h2, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_ORN, 4'h3, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_NOT, 4'h0, 5'h00, 2'h0, 1'b0);
    scan();
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_BLKOR, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_BLKAND, 4'h0, 5'h00, 2'h0, 1'b0);
    scan();
    in_step(`LBLU_FC_WBT, 4'h4, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_WBTN, 4'h4, 5'h00, 2'h1, 1'b0);
    in_step(`LBLU_FC_WBT, 4'h4, 5'h00, 2'h2, 1'b1);
    in_step(`LBLU_FC_WBTN, 4'h5, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_WBT, 4'h5, 5'h00, 2'h1, 1'b0);
  endtask

  // Condition edges, separate history per instance
  task automatic t_edges;
    scan();
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_UP, 4'h0, 5'h03, 2'h0, 1'b1);
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_UP, 4'h0, 5'h03, 2'h0, 1'b0);
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_UP, 4'h0, 5'h05, 2'h0, 1'b1);
    scan();
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_DOWN, 4'h0, 5'h04, 2'h0, 1'b0);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_DOWN, 4'h0, 5'h04, 2'h0, 1'b1);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_DOWN, 4'h0, 5'h04, 2'h0, 1'b0);
  endtask

  // Single-bit writes to word 3 and range writes to word 4, with condition on and off
  task automatic t_outputs;
    scan();
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    out_step(`LBLU_FC_OUT, 16'h0003, 4'h2, 5'h00, 5'h00, 16'h0004);
    check(seen_mask, 16'h0004);
    out_step(`LBLU_FC_OUTN, 16'h0003, 4'h2, 5'h00, 5'h00, 16'h0000);
    out_step(`LBLU_FC_WBOUT, 16'h0003, 4'h5, 5'h00, 5'h00, 16'h0020);
    out_step(`LBLU_FC_SET, 16'h0003, 4'h0, 5'h00, 5'h00, 16'h0021);
    out_step(`LBLU_FC_WBON, 16'h0003, 4'h8, 5'h00, 5'h00, 16'h0121);
    out_step(`LBLU_FC_CLR, 16'h0003, 4'h0, 5'h00, 5'h00, 16'h0120);
    out_step(`LBLU_FC_WBOFF, 16'h0003, 4'h5, 5'h00, 5'h00, 16'h0100);
    out_step(`LBLU_FC_RON, 16'h0004, 4'h3, 5'h05, 5'h00, 16'h00F8);
    out_step(`LBLU_FC_RON, 16'h0004, 4'hC, 5'h10, 5'h00, 16'hF0F8);
    out_step(`LBLU_FC_ROFF, 16'h0004, 4'h4, 5'h02, 5'h00, 16'hF0C8);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    out_step(`LBLU_FC_SET, 16'h0003, 4'h9, 5'h00, 5'h00, 16'h0100);
    out_step(`LBLU_FC_CLR, 16'h0003, 4'h8, 5'h00, 5'h00, 16'h0100);
    out_step(`LBLU_FC_RON, 16'h0004, 4'h0, 5'h03, 5'h00, 16'hF0C8);
    out_step(`LBLU_FC_ROFF, 16'h0004, 4'hC, 5'h04, 5'h00, 16'hF0C8);
    out_step(`LBLU_FC_OUT, 16'h0003, 4'h8, 5'h00, 5'h00, 16'h0000);
  endtask

  // Pulse outputs and latch on word 5
  task automatic t_pulse_latch;
    scan();
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    out_step(`LBLU_FC_PUP, 16'h0005, 4'h0, 5'h00, 5'h06, 16'h0001);
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    out_step(`LBLU_FC_PUP, 16'h0005, 4'h0, 5'h00, 5'h06, 16'h0000);
    out_step(`LBLU_FC_PDN, 16'h0005, 4'h1, 5'h00, 5'h07, 16'h0000);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    out_step(`LBLU_FC_PDN, 16'h0005, 4'h1, 5'h00, 5'h07, 16'h0002);
    out_step(`LBLU_FC_PDN, 16'h0005, 4'h1, 5'h00, 5'h07, 16'h0000);
    scan();
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    out_step(`LBLU_FC_KEEP, 16'h0005, 4'h2, 5'h00, 5'h00, 16'h0004);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    out_step(`LBLU_FC_KEEP, 16'h0005, 4'h2, 5'h00, 5'h00, 16'h0004);
    in_step(`LBLU_FC_LOAD, 4'h1, 5'h00, 2'h0, 1'b0);
    in_step(`LBLU_FC_LOAD, 4'h0, 5'h00, 2'h0, 1'b1);
    out_step(`LBLU_FC_KEEP, 16'h0005, 4'h2, 5'h00, 5'h00, 16'h0000);
  endtask

  // Stack limits: underflow keeps the condition, overflow after 8 pushes
  task automatic t_stack;
    scan();
    in_step(`LBLU_FC_BLKOR, 4'h0, 5'h00, 2'h0, 1'b1);
    check(16'(stack_err), 16'h0001);
    do_reset();
    scan();
    for (int i = 0; i < 9; i++) begin
      run(`LBLU_FC_LOAD, 16'h0001, 4'h0, 5'h00, 2'h0, 5'h00);
      check(16'(stack_err), 16'(i == 8));
    end
    do_reset();
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #400us;
    errors++;
    summarize();
  end

  // Main sequence
  initial begin
    errors      = 0;
    cmp_count   = 0;
    reset       = 1'b1;
    scan_start  = 1'b0;
    instr_valid = 1'b0;
    instr_op    = 10'h000;
    instr_form  = 2'h0;
    instr_edge  = 5'h00;
    op_addr     = 16'h0000;
    op_bit      = 4'h0;
    op_count    = 5'h00;
    for (int i = 0; i < 16; i++) mem.mem[i] = 16'h0000;
    mem.mem[1] = 16'h00A5;
    mem.mem[2] = 16'h0010;
    do_reset();
    t_inputs();
    t_edges();
    t_outputs();
    t_pulse_latch();
    t_stack();
    summarize();
  end
endmodule // tb_top
